// >>> rtc_alarm_and_trim_monitor.sv
// alarm, trim monitors, gain factor and battery sensing schedule
// Notes on behaviour
// [RULE1] battery sensing every ten or one minutes
// [RULE2] sensing disabled means no periodic conversions
// [RULE3] each conversion lasts 22 ms always
// [RULE4] gain loaded at power-up, writes ignored
// [RULE5] gain code scales analog step size
// [RULE6] final analog trim readable, six bits
// [RULE7] final digital trim readable, five bits
// [RULE8] digital trim is sign-magnitude, 30.5 ppm units
// [RULE9] alarm byte top bit enables comparison
// [RULE10] six alarm bytes, no year byte
// [RULE11] alarm fires when enabled bytes all match
// [RULE12] single mode holds pin low until cleared
// [RULE13] pulsed mode pulses pin every match
// [RULE14] host clears flag by writing zero
// [RULE15] auto reset clears flag on status read
// [RULE16] host picks fast rate for swinging temperature
// [RULE17] battery sensing needs enable and good battery
// [RULE18] analog code maps linearly, +32 to -31
// [RULE19] pulse width fixed, under one second
`timescale 1ns/1ps
module rtc_alarm_and_trim_monitor import rtc_trim_pkg::*; #(
	parameter int SEC_CYCLES   = SEC_CYCLES_DEF,
	parameter int CONV_CYCLES  = CONV_CYCLES_DEF,
	parameter int PULSE_CYCLES = PULSE_CYCLES_DEF
) (
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_n_i,
	// register port
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	// calendar from the counters
	input  wire cal_type     cal_i,
	input  wire logic        cal_update_i,
	// supply status pins
	input  wire logic        on_battery_i,
	input  wire logic        vbat_ok_i,
	// production gain value
	input  wire logic [4:0]  gain_code_i,
	// compensation engine
	input  wire trim_type    initial_trim_i,
	input  wire trim_type    comp_trim_i,
	output logic             conv_active_o,
	// decoded trim values
	output logic      [5:0]  gain_step_o,
	output logic      [6:0]  analog_trim_steps_o,
	output logic      [10:0] digital_trim_halfppm_o,
	// open-drain interrupt pin and frequency select
	input  wire logic        irq_or_freq_pin_i,
	output logic             irq_or_freq_pin_o,
	output logic             irq_or_freq_pin_oe_o,
	output logic      [3:0]  freq_sel_o,
	output logic             alarm_flag_o
);

	typedef struct packed {
		logic [ALARM_BYTES-1:0][7:0] alarm; // seconds..weekday alarm bytes
		logic        alarm_flag;
		logic        auto_flag_reset;
		logic        pulsed_irq_select;
		logic [3:0]  freq_sel;
		logic        tse;
		logic        battery_sense_enable;
		logic        battery_sense_rate;
		logic [4:0]  gain;
		logic        gain_loaded;
		trim_type    final_trim;
		logic [31:0] pulse_cnt;
		logic        pin_oe;
		logic [7:0]  rdata;
		logic        bat_s1;
		logic        bat_s2;
		logic        vok_s1;
		logic        vok_s2;
		logic [5:0]  gain_step;
		logic [6:0]  at_steps;
		logic [10:0] dt_halfppm;
	} mon_type;

	mon_type                r;           // registered state
	mon_type                n;           // next state
	logic [ALARM_BYTES-1:0] byte_hit;    // per byte: disabled or equal
	logic [ALARM_BYTES-1:0] byte_en;     // per byte enable
	logic                   match;       // alarm condition this update
	logic                   sense_on;    // scheduler enable
	logic                   conv_done;   // conversion end pulse
	logic [ALARM_BYTES-1:0][7:0] cal_bytes; // calendar in alarm order
	logic [10:0]            dt_mag;      // digital magnitude in 0.5 ppm

	assign cal_bytes = cal_i;

	// per-byte compare; the top bit is the enable, the rest must equal the calendar
	for (genvar g = 0; g < ALARM_BYTES; g++) begin : g_cmp
		assign byte_en[g]  = r.alarm[g][ALARM_EN_BIT]; // see [RULE9]
		assign byte_hit[g] = !byte_en[g] ||
			(r.alarm[g][ALARM_EN_BIT-1:0] == cal_bytes[g][ALARM_EN_BIT-1:0]);
	end

	// fire only on a calendar step, and only with something enabled
	assign match = cal_update_i && (|byte_en) && (&byte_hit); // see [RULE11]

	// battery side needs the enable and a healthy cell; main side uses the sense enable
	assign sense_on = r.bat_s2 ? (r.battery_sense_enable && r.vok_s2) : r.tse; // see [RULE17]

	assign dt_mag = 11'(r.final_trim.digital_trim[3:0] * DT_HALF_PPM);

	// conversion timing
	sense_scheduler #(
		.SEC_CYCLES  (SEC_CYCLES),
		.CONV_CYCLES (CONV_CYCLES)
	) u_sched (
		.sys_clk_i     (sys_clk_i),
		.rst_n_i       (rst_n_i),
		.enable_i      (sense_on),
		.fast_rate_i   (r.battery_sense_rate),
		.conv_active_o (conv_active_o),
		.conv_done_o   (conv_done)
	);

	// next-state logic
	always_comb begin
		n = r;
		// pin synchronisers
		n.bat_s1 = on_battery_i;
		n.bat_s2 = r.bat_s1;
		n.vok_s1 = vbat_ok_i;
		n.vok_s2 = r.vok_s1;

		// production gain is caught once after reset, never written by the host
		if (!r.gain_loaded) begin // see [RULE4]
			n.gain        = gain_code_i;
			n.gain_loaded = 1'b1;
		end

		// trim monitors follow the engine at each conversion end while tse is set, else the initial trims
		if (!r.tse) begin
			n.final_trim = initial_trim_i;
		end else if (conv_done) begin
			n.final_trim = comp_trim_i;
		end

		// register writes
		if (reg_wr_i) begin
			if (reg_addr_i == ADDR_STATUS && !reg_wdata_i[STAT_ALARM_BIT]) begin
				n.alarm_flag = 1'b0; // host writes zero to clear, see [RULE14]
			end
			if (reg_addr_i == ADDR_CONTROL) begin
				n.auto_flag_reset   = reg_wdata_i[CTRL_AUTO_FLAG_RESET_BIT];
				n.pulsed_irq_select = reg_wdata_i[CTRL_IM_BIT];
				n.freq_sel          = reg_wdata_i[3:0];
			end
			if (reg_addr_i == ADDR_SENSE) begin // only the top three bits take a write
				n.tse                  = reg_wdata_i[SENSE_TSE_BIT];
				n.battery_sense_enable = reg_wdata_i[SENSE_BATTERY_SENSE_ENABLE_BIT];
				n.battery_sense_rate   = reg_wdata_i[SENSE_BATTERY_SENSE_RATE_BIT];
			end
			// only six bytes exist, so no year compare is possible, see [RULE10]
			if (reg_addr_i >= ADDR_ALARM_LO && reg_addr_i <= ADDR_ALARM_HI) begin
				n.alarm[3'(reg_addr_i - ADDR_ALARM_LO)] = reg_wdata_i;
			end
		end

		// register reads, answered one cycle later
		if (reg_rd_i) begin
			if (reg_addr_i == ADDR_STATUS && r.auto_flag_reset) begin
				n.alarm_flag = 1'b0; // read clears the flag, see [RULE15]
			end
			if (reg_addr_i == ADDR_STATUS) begin
				n.rdata = 8'(r.alarm_flag) << STAT_ALARM_BIT;
			end else if (reg_addr_i == ADDR_CONTROL) begin
				n.rdata = {r.auto_flag_reset, r.pulsed_irq_select, 2'b00, r.freq_sel};
			end else if (reg_addr_i == ADDR_SENSE) begin
				n.rdata = {r.tse, r.battery_sense_enable, r.battery_sense_rate, r.gain};
			end else if (reg_addr_i == ADDR_FINAL_AT) begin
				n.rdata = {2'b00, r.final_trim.analog_trim}; // see [RULE6]
			end else if (reg_addr_i == ADDR_FINAL_DT) begin
				n.rdata = {3'b000, r.final_trim.digital_trim}; // see [RULE7]
			end else if (reg_addr_i >= ADDR_ALARM_LO && reg_addr_i <= ADDR_ALARM_HI) begin
				n.rdata = r.alarm[3'(reg_addr_i - ADDR_ALARM_LO)];
			end else begin
				n.rdata = RDATA_RST; // unmapped here reads zero
			end
		end

		// a match sets the flag after any clear so the event is never lost
		if (match) begin
			n.alarm_flag = 1'b1;
		end

		// pulse timer restarts at every match in pulsed mode
		if (match && r.pulsed_irq_select) begin
			n.pulse_cnt = 32'(PULSE_CYCLES); // see [RULE19]
		end else if (r.pulse_cnt != '0) begin
			n.pulse_cnt = 32'(r.pulse_cnt - 32'd1);
		end

		// pin drive: frequency output owns the pin when selected
		if (r.freq_sel != FSEL_OFF) begin
			n.pin_oe = 1'b0;
		end else if (r.pulsed_irq_select) begin
			n.pin_oe = (n.pulse_cnt != '0); // see [RULE13]
		end else begin
			n.pin_oe = n.alarm_flag; // see [RULE12]
		end

		// gain step in sixteenths; reserved codes 9..15 fall back to unity
		if (r.gain == 5'h00) begin // see [RULE5]
			n.gain_step = GAIN_UNITY;
		end else if (r.gain <= GAIN_LOW_MAX) begin
			n.gain_step = 6'(GAIN_UNITY - {1'b0, r.gain});
		end else if (r.gain[4]) begin
			n.gain_step = 6'({1'b0, r.gain} + 6'd1);
		end else begin
			n.gain_step = GAIN_UNITY;
		end

		// analog steps: 32 minus the code, as a signed value
		n.at_steps = 7'(AT_ZERO_CODE - {1'b0, r.final_trim.analog_trim}); // see [RULE18]

		// digital trim: bit 4 negates the magnitude
		n.dt_halfppm = r.final_trim.digital_trim[4] ? 11'(~dt_mag + 11'd1) : dt_mag; // see [RULE8]
	end

	// state register; the gain strap is caught by the clocked path after release
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '{alarm: {ALARM_BYTES{ALARM_RST}}, freq_sel: FSEL_OFF, rdata: RDATA_RST,
				gain_step: GAIN_UNITY, at_steps: AT_ZERO_CODE, default: '0};
		end else begin
			r <= n;
		end
	end

	// outputs straight from flops, except the pin data tied low
	assign reg_rdata_o            = r.rdata;
	assign irq_or_freq_pin_o      = 1'b0;
	assign irq_or_freq_pin_oe_o   = r.pin_oe;
	assign freq_sel_o             = r.freq_sel;
	assign alarm_flag_o           = r.alarm_flag;
	assign gain_step_o            = r.gain_step;
	assign analog_trim_steps_o    = r.at_steps;
	assign digital_trim_halfppm_o = r.dt_halfppm;

endmodule // rtc_alarm_and_trim_monitor

// >>> rtc_alarm_trim_checker_assertions.sv
// port-level assertions for the alarm and trim monitor
`timescale 1ns/1ps
module rtc_alarm_trim_checker import rtc_trim_pkg::*; #(
	parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
	// clock and reset
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// alarm, schedule and gain
	input wire logic       cal_update_i,
	input wire logic       conv_active_o,
	input wire logic [5:0] gain_step_o,
	input wire logic       irq_or_freq_pin_oe_o,
	input wire logic [3:0] freq_sel_o,
	input wire logic       alarm_flag_o
);
	int conv_cnt_r; // cycles spent in the running conversion

	// counted here since a repetition may not take a parameter
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			conv_cnt_r <= 0;
		end else begin
			conv_cnt_r <= conv_active_o ? conv_cnt_r + 1 : 0;
		end
	end

	default clocking dc @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	flag_cause_a: assert property ($rose(alarm_flag_o) |-> $past(cal_update_i))
		else $error("alarm flag rose without a calendar update");
	pin_assert_a: assert property ($rose(alarm_flag_o) && freq_sel_o == FSEL_OFF
		&& $stable(freq_sel_o) |=> irq_or_freq_pin_oe_o)
		else $error("pin not pulled low after alarm");
	freq_owns_a: assert property (freq_sel_o != FSEL_OFF
		&& $past(freq_sel_o) != FSEL_OFF |-> !irq_or_freq_pin_oe_o)
		else $error("alarm drove pin while frequency output selected");
	pulse_width_a: assert property ($fell(irq_or_freq_pin_oe_o) && alarm_flag_o
		&& $stable(freq_sel_o) |-> $past(irq_or_freq_pin_oe_o, 4)
		&& !$past(irq_or_freq_pin_oe_o, 5))
		else $error("interrupt pulse width wrong");
	clear_release_a: assert property ($fell(alarm_flag_o) |=> !irq_or_freq_pin_oe_o)
		else $error("pin held after flag cleared");
	conv_len_a: assert property ($fell(conv_active_o) |-> conv_cnt_r == CONV_CYCLES)
		else $error("conversion length wrong");
	at_pad_a: assert property (reg_rd_i && reg_addr_i == ADDR_FINAL_AT
		|=> reg_rdata_o[7:6] == 2'h0)
		else $error("analog trim upper bits not zero");
	dt_pad_a: assert property (reg_rd_i && reg_addr_i == ADDR_FINAL_DT
		|=> reg_rdata_o[7:5] == 3'h0)
		else $error("digital trim upper bits not zero");
	gain_hold_a: assert property ($past(rst_n_i) && $past(rst_n_i, 2)
		&& $past(rst_n_i, 3) |-> $stable(gain_step_o))
		else $error("gain step changed after power-up");

	cover property ($rose(alarm_flag_o));
	cover property ($fell(conv_active_o));
	cover property ($fell(irq_or_freq_pin_oe_o) && alarm_flag_o);
endmodule // rtc_alarm_trim_checker

bind rtc_alarm_and_trim_monitor rtc_alarm_trim_checker #(.CONV_CYCLES(CONV_CYCLES)) chk_i (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
	.reg_rdata_o(reg_rdata_o), .cal_update_i(cal_update_i), .conv_active_o(conv_active_o),
	.gain_step_o(gain_step_o), .irq_or_freq_pin_oe_o(irq_or_freq_pin_oe_o),
	.freq_sel_o(freq_sel_o), .alarm_flag_o(alarm_flag_o)
);

// >>> rtc_host_model.sv
// host side model speaking the register strobe protocol
`timescale 1ns/1ps
module rtc_host_model (
	// clock
	input  wire logic       sys_clk_i,
	// register port towards the device
	output logic      [7:0] reg_addr_o,
	output logic      [7:0] reg_wdata_o,
	output logic            reg_wr_o,
	output logic            reg_rd_o,
	input  wire logic [7:0] reg_rdata_i
);
	// idle bus at time zero
	initial begin
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end

	// one strobe cycle; idle lines then carry inverted junk, not the old value
	task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge sys_clk_i);
		#1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = w;
		reg_rd_o = !w;
		@(posedge sys_clk_i);
		#1;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		access(a, d, 1'b1);
	endtask

	// read data is valid in the cycle after the taken edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		access(a, 8'h00, 1'b0);
		d = reg_rdata_i;
	endtask
endmodule // rtc_host_model

// >>> rtc_trim_pkg.sv
// shared constants, types and register map for the alarm and trim monitor block
package rtc_trim_pkg;

	// clock and timing
	localparam int CLK_HZ          = 200_000_000;          // system clock rate
	localparam int SEC_CYCLES_DEF  = CLK_HZ;               // cycles in one second
	localparam int CONV_TIME_MS    = 22;                   // conversion time, ms
	localparam int CONV_CYCLES_DEF = CONV_TIME_MS * (CLK_HZ / 1000);
	localparam int PULSE_TIME_MS   = 250;                  // pulsed irq low time, ms
	localparam int PULSE_CYCLES_DEF = PULSE_TIME_MS * (CLK_HZ / 1000);

	// measurement periods in minutes
	localparam logic [9:0] SLOW_PERIOD_MIN = 10'd10;       // rate bit clear
	localparam logic [9:0] FAST_PERIOD_MIN = 10'd1;        // rate bit set
	localparam logic [9:0] SEC_PER_MIN     = 10'd60;

	// register byte addresses
	localparam logic [7:0] ADDR_STATUS    = 8'h07;
	localparam logic [7:0] ADDR_CONTROL   = 8'h08;
	localparam logic [7:0] ADDR_SENSE     = 8'h0d;
	localparam logic [7:0] ADDR_FINAL_AT  = 8'h0e;
	localparam logic [7:0] ADDR_FINAL_DT  = 8'h0f;
	localparam logic [7:0] ADDR_ALARM_LO  = 8'h10;
	localparam logic [7:0] ADDR_ALARM_HI  = 8'h15;
	localparam int         ALARM_BYTES    = 6;

	// field positions
	localparam int STAT_ALARM_BIT   = 4;   // alarm_flag in status
	localparam int CTRL_AUTO_FLAG_RESET_BIT    = 7;   // auto_flag_reset
	localparam int CTRL_IM_BIT      = 6;   // pulsed_irq_select
	localparam int SENSE_TSE_BIT    = 7;   // temperature sense enable
	localparam int SENSE_BATTERY_SENSE_ENABLE_BIT   = 6;   // battery_sense_enable
	localparam int SENSE_BATTERY_SENSE_RATE_BIT   = 5;   // battery_sense_rate
	localparam int ALARM_EN_BIT     = 7;   // match enable in each alarm byte

	// reset values
	localparam logic [7:0] ALARM_RST    = 8'h00;
	localparam logic [7:0] RDATA_RST    = 8'h00;
	localparam logic [3:0] FSEL_OFF     = 4'h0;   // frequency output disabled

	// trim arithmetic
	localparam logic [6:0]  AT_ZERO_CODE = 7'd32;  // code giving zero steps
	localparam logic [10:0] DT_HALF_PPM  = 11'd61; // one digital step, 0.5 ppm units
	localparam logic [5:0]  GAIN_UNITY   = 6'd16;  // unity step, 1/16 units
	localparam logic [4:0]  GAIN_LOW_MAX = 5'h08;  // deepest reduction code

	// carrier types
	typedef struct packed {
		logic [7:0] weekday;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} cal_type;

	typedef struct packed {
		logic [5:0] analog_trim;
		logic [4:0] digital_trim;
	} trim_type;

	typedef enum logic [1:0] {
		SCH_IDLE = 2'b00,
		SCH_WAIT = 2'b01,
		SCH_CONV = 2'b10
	} sched_state_type;

endpackage

// >>> sense_scheduler.sv
// periodic temperature conversion scheduler
`timescale 1ns/1ps
module sense_scheduler import rtc_trim_pkg::*; #(
	parameter int SEC_CYCLES  = SEC_CYCLES_DEF,
	parameter int CONV_CYCLES = CONV_CYCLES_DEF
) (
	// clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_n_i,
	// control
	input  wire logic enable_i,      // sensing allowed now
	input  wire logic fast_rate_i,   // one-minute period
	// converter handshake
	output logic      conv_active_o, // conversion window
	output logic      conv_done_o    // one-cycle end pulse
);

	typedef struct packed {
		sched_state_type st;
		logic [31:0]     tick;       // cycles inside the current second
		logic [9:0]      secs;       // seconds inside the current period
		logic [31:0]     conv;       // cycles inside the conversion
		logic            active;
		logic            done;
	} sch_type;

	sch_type    r;      // registered state
	sch_type    n;      // next state
	logic [9:0] period; // period in seconds

	// period length from the rate bit
	assign period = 10'((fast_rate_i ? FAST_PERIOD_MIN : SLOW_PERIOD_MIN) * SEC_PER_MIN);

	// next-state logic
	always_comb begin
		n      = r;
		n.done = 1'b0;
		unique case (r.st)
			SCH_IDLE: begin
				if (enable_i) begin // start a fresh period
					n.st   = SCH_WAIT;
					n.tick = '0;
					n.secs = '0;
				end
			end
			SCH_WAIT: begin
				if (!enable_i) begin // no periodic conversion when disabled, see [RULE2]
					n.st = SCH_IDLE;
				end else if (r.tick == 32'(SEC_CYCLES - 1)) begin
					n.tick = '0;
					if (r.secs == 10'(period - 10'd1)) begin // period reached, see [RULE1]
						n.st     = SCH_CONV;
						n.conv   = '0;
						n.active = 1'b1;
					end else begin
						n.secs = 10'(r.secs + 10'd1);
					end
				end else begin
					n.tick = 32'(r.tick + 32'd1);
				end
			end
			SCH_CONV: begin
				// a started conversion always runs to its end so the trims stay coherent
				if (r.conv == 32'(CONV_CYCLES - 1)) begin // fixed duration, see [RULE3]
					n.active = 1'b0;
					n.done   = 1'b1;
					n.st     = enable_i ? SCH_WAIT : SCH_IDLE;
					n.tick   = '0;
					n.secs   = '0;
				end else begin
					n.conv = 32'(r.conv + 32'd1);
				end
			end
			default: begin // unused code
				n.st = SCH_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			r <= '{st: SCH_IDLE, tick: '0, secs: '0, conv: '0, active: 1'b0, done: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign conv_active_o = r.active;
	assign conv_done_o   = r.done;

endmodule // sense_scheduler

// >>> tb_rtc_alarm_and_trim_monitor.sv
// self-checking bench for the alarm and trim monitor block
`timescale 1ns/1ps
module tb_rtc_alarm_and_trim_monitor import rtc_trim_pkg::*;;
	localparam int FAST = 600;  // one minute of ten-cycle seconds
	localparam int SLOW = 6000; // ten minutes
	logic        sys_clk_i, rst_n_i, cal_upd, on_bat, vbat_ok, conv_active;
	logic        reg_wr, reg_rd, pin_o, pin_oe, flag;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d;
	logic [4:0]  gain_code;
	logic [5:0]  gain_step;
	logic [6:0]  at_steps;
	logic [10:0] dt_hppm;
	logic [3:0]  fsel;
	cal_type     cal;
	trim_type    init_trim, comp_trim;
	int          n_mismatch, samples_checked;

	rtc_host_model host (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata),
		.reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_rdata_i(reg_rdata));

	// pulled-up pin: low only while the device sinks it
	rtc_alarm_and_trim_monitor #(.SEC_CYCLES(10), .CONV_CYCLES(5), .PULSE_CYCLES(4)) uut (
		.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
		.cal_i(cal), .cal_update_i(cal_upd), .on_battery_i(on_bat), .vbat_ok_i(vbat_ok),
		.gain_code_i(gain_code), .initial_trim_i(init_trim), .comp_trim_i(comp_trim),
		.conv_active_o(conv_active), .gain_step_o(gain_step), .analog_trim_steps_o(at_steps),
		.digital_trim_halfppm_o(dt_hppm), .irq_or_freq_pin_i(!pin_oe),
		.irq_or_freq_pin_o(pin_o), .irq_or_freq_pin_oe_o(pin_oe), .freq_sel_o(fsel),
		.alarm_flag_o(flag));

	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [10:0] got, input logic [10:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
		host.rd(a, d);
		chk({3'h0, d}, {3'h0, exp});
	endtask

	// one calendar advance carrying seconds and minutes
	task automatic hit(input logic [7:0] s, input logic [7:0] m);
		@(posedge sys_clk_i);
		#1;
		cal.second = s;
		cal.minute = m;
		cal_upd = 1'b1;
		tick(1);
		cal_upd = 1'b0;
	endtask

	task automatic do_reset(input logic [4:0] g);
		gain_code = g;
		rst_n_i = 1'b0;
		tick(16);
		rst_n_i = 1'b1;
		tick(3);
		gain_code = ~g; // strap moves after capture and must be ignored
	endtask

	// bounded wait for a conversion; expected count window lo..hi
	task automatic wait_conv(input int lim, input int lo, input int hi);
		int n;
		n = 0;
		while (conv_active !== 1'b1 && n < lim) begin
			tick(1);
			n++;
		end
		chk(11'(n >= lo && n <= hi), 11'h1);
		if (n == lim && lo != lim) begin
			final_report();
		end
		// a seen conversion must close after its fixed window; a stuck one counts a mismatch
		if (n < lim) begin
			n = 0;
			while (conv_active === 1'b1 && n < 20) begin
				tick(1);
				n++;
			end
			chk(11'(n), 11'd5);
		end
	endtask

	initial begin
		{cal_upd, on_bat, n_mismatch, samples_checked} = '0;
		cal = '0;
		vbat_ok = 1'b1;
		init_trim = '{analog_trim: 6'h2a, digital_trim: 5'h1a};
		comp_trim = '{analog_trim: 6'h05, digital_trim: 5'h03};
		do_reset(5'h13);
		tick(2);
		chk(gain_step, 6'd20);
		host.wr(ADDR_SENSE, 8'h1f);
		rdchk(ADDR_SENSE, 8'h13);
		host.wr(ADDR_FINAL_AT, 8'hff);
		rdchk(ADDR_FINAL_AT, 8'h2a);
		host.wr(ADDR_FINAL_DT, 8'h00);
		rdchk(ADDR_FINAL_DT, 8'h1a);
		chk(at_steps, 7'h76);
		chk(dt_hppm, 11'h59e);
		// seconds and minutes enabled, hours value set but not enabled
		host.wr(8'h10, 8'hb0);
		host.wr(8'h11, 8'h85);
		host.wr(8'h12, 8'h12);
		host.wr(8'h16, 8'h55);
		rdchk(8'h16, 8'h00);
		rdchk(8'h11, 8'h85);
		hit(8'h30, 8'h07);
		chk(flag, 1'b0);
		hit(8'h30, 8'h05);
		chk(flag, 1'b1);
		tick(9);
		chk(pin_oe, 1'b1);
		host.wr(ADDR_STATUS, 8'h00);
		chk(flag, 1'b0);
		host.wr(ADDR_CONTROL, 8'h80);
		hit(8'h30, 8'h05);
		host.rd(ADDR_STATUS, d);
		chk(d[4], 1'b1);
		chk(flag, 1'b0);
		host.wr(ADDR_CONTROL, 8'h40);
		for (int k = 0; k < 2; k++) begin
			hit(8'h30, 8'h05);
			tick(1);
			chk(pin_oe, 1'b1);
			tick(4);
			chk(pin_oe, 1'b0);
		end
		chk(flag, 1'b1);
		host.wr(ADDR_STATUS, 8'h00);
		host.wr(ADDR_CONTROL, 8'h01);
		chk(fsel, 4'h1);
		hit(8'h30, 8'h05);
		tick(2);
		// open-drain data stays low; only the enable may sink the pin
		chk({pin_o, flag, pin_oe}, 3'b010);
		host.wr(ADDR_STATUS, 8'h00);
		do_reset(5'h08);
		chk(gain_step, 6'd8);
		on_bat = 1'b1;
		host.wr(ADDR_SENSE, 8'h20);
		wait_conv(1000, 1000, 1000);
		vbat_ok = 1'b0;
		host.wr(ADDR_SENSE, 8'h60); // fast rate for a swinging temperature
		wait_conv(1000, 1000, 1000);
		vbat_ok = 1'b1;
		wait_conv(700, FAST, FAST + 8);
		wait_conv(700, FAST - 1, FAST + 2);
		host.wr(ADDR_SENSE, 8'h00);
		// sense enable on too, so the conversion end loads the engine's trims
		host.wr(ADDR_SENSE, 8'hc0);
		wait_conv(6100, SLOW, SLOW + 8);
		rdchk(ADDR_FINAL_AT, 8'h05);
		rdchk(ADDR_FINAL_DT, 8'h03);
		final_report();
	end
endmodule // tb_rtc_alarm_and_trim_monitor
